// ### include/ptg_pkg.sv
// Shared constants of the PWM timer register guard.
`default_nettype none
package ptg_pkg;
   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [5:0] IDX_PRESCALE_EN = 6'h00;
   localparam logic [5:0] IDX_WAVE_MODE = 6'h01;
   localparam logic [5:0] IDX_OUT_ROUTING = 6'h02;
   localparam logic [5:0] IDX_OVERRIDE_LVL = 6'h03;
   localparam logic [5:0] IDX_CMD_STROBES = 6'h04;
   localparam logic [5:0] IDX_EVENT_A = 6'h08;
   localparam logic [5:0] IDX_EVENT_B = 6'h09;
   localparam logic [5:0] IDX_INT_ENABLE = 6'h0c;
   localparam logic [5:0] IDX_INT_FLAGS = 6'h0d;
   localparam logic [5:0] IDX_STATUS = 6'h0e;
   localparam logic [5:0] IDX_INPUT_A = 6'h10;
   localparam logic [5:0] IDX_INPUT_B = 6'h11;
   localparam logic [5:0] IDX_FAULT_DEF = 6'h12;
   localparam logic [5:0] IDX_DELAY_CTRL = 6'h14;
   localparam logic [5:0] IDX_DELAY_VAL = 6'h15;
   localparam logic [5:0] IDX_DITHER_CTRL = 6'h18;
   localparam logic [5:0] IDX_DITHER_VAL = 6'h19;
   localparam logic [5:0] IDX_DEBUG_CTRL = 6'h1e;
   localparam logic [5:0] IDX_CAPTURE_A = 6'h22;
   localparam logic [5:0] IDX_CAPTURE_B = 6'h24;
   localparam logic [5:0] IDX_CMP_A_SET = 6'h28;
   localparam logic [5:0] IDX_CMP_A_CLR = 6'h2a;
   localparam logic [5:0] IDX_CMP_B_SET = 6'h2c;
   localparam logic [5:0] IDX_CMP_B_CLR = 6'h2e;
   localparam logic [5:0] IDX_PROT_KEY = 6'h30;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_ENABLE = 0;
   localparam int BIT_FIFTY = 3;
   localparam int BIT_SCAPT_A = 3;
   localparam int BIT_SCAPT_B = 4;
   localparam int BIT_EN_READY = 0;
   localparam int BIT_CMD_READY = 1;
   localparam int BIT_RUNNING = 6;
   // ************************************************************
   // Reset values, unlock key and window length
   // ************************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [11:0] RST_CMP = 12'h000;
   localparam logic [7:0] IO_REG_UNLOCK_KEY = 8'h5a; // Value arbitrary
   localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
   localparam logic [1:0] SLEEP_STANDBY = 2'h2;
endpackage : ptg_pkg
`default_nettype wire

// ### include/ptg_xing_if.sv
// Signals passed between the bus domain and the timer domain.
`timescale 1ns/1ps
`default_nettype none
interface ptg_xing_if;
   logic en_req_tgl; // Enable transfer request toggle
   logic en_val; // Enable value, stable while request pending
   logic en_ack_tgl; // Enable transfer done toggle
   logic cap_req_tgl; // Capture request toggle
   logic cap_sel_b; // Capture target, 1 selects B
   logic cap_ack_tgl; // Capture done toggle
   logic [11:0] cap_val; // Captured count, stable after done
   logic [11:0] cnt_top; // Counter wrap value
   logic deep_sleep; // Standby or power-down level
   modport reg_side (output en_req_tgl, en_val, cap_req_tgl, cap_sel_b, cnt_top, deep_sleep,
                     input en_ack_tgl, cap_ack_tgl, cap_val);
   modport core_side (input en_req_tgl, en_val, cap_req_tgl, cap_sel_b, cnt_top, deep_sleep,
                      output en_ack_tgl, cap_ack_tgl, cap_val);
endinterface : ptg_xing_if
`default_nettype wire

// ### rtl/ptg_reg_guard.sv
// Register bank of the PWM timer with protected-write guard, Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The timer keeps counting while the system sleeps lightly with peripherals clocked.
// - The timer stops and does not advance in standby or power-down sleep.
// - Enable and capture values cross through synchronised handshakes, the sleep level through a synchroniser, cnt_top directly.
// - A protected write is taken only within four bus transactions after the key write.
// - Writes to a protected register are always acknowledged but change nothing while locked.
// - Only the fault output defaults register is protected, by the I/O register key.
// - Every reset reloads the fault defaults from the fuse; only power-on clears it first.
// - An enable write crosses to the timer and further enable writes keep the old enable bit until it lands.
module ptg_reg_guard (
   input wire logic clk_i, // Clock, 25 MHz
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic por_i, // High with rst_i when reset is power-on
   input wire logic [7:0] timer_config_fuse_i, // Fuse image for fault defaults
   input wire logic [1:0] sleep_mode_i, // 0 run, 1 idle, 2 standby, 3 power-down
   input wire logic [7:0] adr_i, // Wishbone byte address
   input wire logic [31:0] dat_i, // Wishbone write data
   input wire logic [3:0] sel_i, // Wishbone byte selects
   input wire logic we_i, // Wishbone write enable
   input wire logic cyc_i, // Wishbone cycle
   input wire logic stb_i, // Wishbone strobe
   output logic [31:0] dat_o, // Wishbone read data
   output logic ack_o, // Wishbone acknowledge
   output logic [7:0] fault_output_defaults_o, // Protected register contents
   output logic [11:0] count_o, // Timer count
   output logic running_o // Timer advancing
);
   // ************************************************************
   // Storage
   // ************************************************************
   logic [7:0] byte_q [0:31];
   logic [11:0] cmp_a_set_q, cmp_a_clr_q, cmp_b_set_q, cmp_b_clr_q;
   logic [11:0] capt_a_q, capt_b_q;
   logic [2:0] win_q;
   logic fuse_load_q;
   logic en_pend_q, cap_pend_q;
   logic en_ack_s, cap_ack_s;
   logic [31:0] rd_d;
   logic req, wr_fire, fire, lo_wr, hi_wr;
   logic [5:0] idx;
   logic [11:0] wr12;
   logic [7:0] wb8;

   ptg_xing_if xing ();

   assign req = cyc_i && stb_i;
   assign fire = req && ack_o;
   assign wr_fire = fire && we_i;
   assign idx = adr_i[7:2];
   assign lo_wr = wr_fire && sel_i[0];
   assign hi_wr = wr_fire && sel_i[1];
   assign wb8 = dat_i[7:0];

   // Plain byte registers and the prescale-enable byte share one array, the rest live apart
   function automatic logic plain_byte(input logic [5:0] i);
      plain_byte = (i == ptg_pkg::IDX_WAVE_MODE) || (i == ptg_pkg::IDX_OUT_ROUTING) ||
                   (i == ptg_pkg::IDX_OVERRIDE_LVL) || (i == ptg_pkg::IDX_EVENT_A) ||
                   (i == ptg_pkg::IDX_EVENT_B) || (i == ptg_pkg::IDX_INT_ENABLE) ||
                   (i == ptg_pkg::IDX_INPUT_A) || (i == ptg_pkg::IDX_INPUT_B) ||
                   (i == ptg_pkg::IDX_DELAY_CTRL) || (i == ptg_pkg::IDX_DELAY_VAL) ||
                   (i == ptg_pkg::IDX_DITHER_CTRL) || (i == ptg_pkg::IDX_DITHER_VAL) ||
                   (i == ptg_pkg::IDX_DEBUG_CTRL);
   endfunction : plain_byte

   // Merge a 16-bit write into a 12-bit value by lane
   function automatic logic [11:0] merge12(input logic [11:0] old, input logic [15:0] d,
                                           input logic [1:0] s);
      merge12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge12

   // ************************************************************
   // Wishbone slave: answer one cycle after the request
   // ************************************************************
   // Ack drops the cycle after it is given so a held request is not taken twice
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req && !ack_o;
      end
   end

   // Read data is registered with the ack; unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req && !ack_o) begin
         dat_o <= rd_d;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (plain_byte(idx)) begin
         rd_d = {24'h00_0000, byte_q[idx[4:0]]};
      end else if (idx == ptg_pkg::IDX_PRESCALE_EN) begin
         rd_d = {24'h00_0000, byte_q[ptg_pkg::IDX_PRESCALE_EN[4:0]]};
      end else if (idx == ptg_pkg::IDX_STATUS) begin
         rd_d[ptg_pkg::BIT_EN_READY] = !en_pend_q;
         rd_d[ptg_pkg::BIT_CMD_READY] = !cap_pend_q;
         rd_d[ptg_pkg::BIT_RUNNING] = running_o;
      end else if (idx == ptg_pkg::IDX_FAULT_DEF) begin
         rd_d = {24'h00_0000, fault_output_defaults_o};
      end else if (idx == ptg_pkg::IDX_CAPTURE_A) begin
         rd_d = {20'h0_0000, capt_a_q};
      end else if (idx == ptg_pkg::IDX_CAPTURE_B) begin
         rd_d = {20'h0_0000, capt_b_q};
      end else if (idx == ptg_pkg::IDX_CMP_A_SET) begin
         rd_d = {20'h0_0000, cmp_a_set_q};
      end else if (idx == ptg_pkg::IDX_CMP_A_CLR) begin
         rd_d = {20'h0_0000, cmp_a_clr_q};
      end else if (idx == ptg_pkg::IDX_CMP_B_SET) begin
         rd_d = {20'h0_0000, cmp_b_set_q};
      end else if (idx == ptg_pkg::IDX_CMP_B_CLR) begin
         rd_d = {20'h0_0000, cmp_b_clr_q};
      end
   end

   // ************************************************************
   // Freely writable registers
   // ************************************************************
   // Interrupt flags and status hold no stored state here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 32; i++) begin
            byte_q[i] <= ptg_pkg::RST_BYTE;
         end
      end else if (lo_wr && plain_byte(idx)) begin
         byte_q[idx[4:0]] <= wb8;
      end else if (lo_wr && idx == ptg_pkg::IDX_PRESCALE_EN) begin
         // Enable bit is kept while its transfer is still in flight
         byte_q[ptg_pkg::IDX_PRESCALE_EN[4:0]] <= {wb8[7:1], en_pend_q ?
            byte_q[ptg_pkg::IDX_PRESCALE_EN[4:0]][ptg_pkg::BIT_ENABLE] : wb8[0]};
      end
   end

   // Compare points; fifty-percent mode mirrors B writes into A
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_a_set_q <= ptg_pkg::RST_CMP;
         cmp_a_clr_q <= ptg_pkg::RST_CMP;
         cmp_b_set_q <= ptg_pkg::RST_CMP;
         cmp_b_clr_q <= ptg_pkg::RST_CMP;
      end else if (lo_wr || hi_wr) begin
         if (idx == ptg_pkg::IDX_CMP_A_SET) begin
            cmp_a_set_q <= merge12(cmp_a_set_q, dat_i[15:0], sel_i[1:0]);
         end else if (idx == ptg_pkg::IDX_CMP_A_CLR) begin
            cmp_a_clr_q <= merge12(cmp_a_clr_q, dat_i[15:0], sel_i[1:0]);
         end else if (idx == ptg_pkg::IDX_CMP_B_SET) begin
            cmp_b_set_q <= merge12(cmp_b_set_q, dat_i[15:0], sel_i[1:0]);
            if (byte_q[ptg_pkg::IDX_OUT_ROUTING[4:0]][ptg_pkg::BIT_FIFTY]) begin
               cmp_a_set_q <= merge12(cmp_a_set_q, dat_i[15:0], sel_i[1:0]);
            end
         end else if (idx == ptg_pkg::IDX_CMP_B_CLR) begin
            cmp_b_clr_q <= merge12(cmp_b_clr_q, dat_i[15:0], sel_i[1:0]);
            if (byte_q[ptg_pkg::IDX_OUT_ROUTING[4:0]][ptg_pkg::BIT_FIFTY]) begin
               cmp_a_clr_q <= merge12(cmp_a_clr_q, dat_i[15:0], sel_i[1:0]);
            end
         end
      end
   end

   // ************************************************************
   // Protected-write guard
   // ************************************************************
   // Window counts completed bus transactions, one per processor access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_q <= 3'h0;
      end else if (lo_wr && idx == ptg_pkg::IDX_PROT_KEY &&
                   wb8 == ptg_pkg::IO_REG_UNLOCK_KEY) begin
         win_q <= ptg_pkg::UNLOCK_WINDOW;
      end else if (wr_fire && idx == ptg_pkg::IDX_FAULT_DEF) begin
         win_q <= 3'h0;
      end else if (fire && win_q != 3'h0) begin
         win_q <= win_q - 3'h1;
      end
   end

   // Power-on clears; the fuse load follows on the edge after release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fuse_load_q <= 1'b1;
         if (por_i) begin
            fault_output_defaults_o <= 8'h00;
         end
      end else if (fuse_load_q) begin
         fuse_load_q <= 1'b0;
         fault_output_defaults_o <= timer_config_fuse_i;
      end else if (lo_wr && idx == ptg_pkg::IDX_FAULT_DEF && win_q != 3'h0) begin
         fault_output_defaults_o <= wb8;
      end
   end

   // ************************************************************
   // Crossing into the timer domain
   // ************************************************************
   ptg_sync_bit u_en_ack (.clk_i(clk_i), .rst_i(rst_i), .d_i(xing.en_ack_tgl),
                          .q_o(en_ack_s));
   ptg_sync_bit u_cap_ack (.clk_i(clk_i), .rst_i(rst_i), .d_i(xing.cap_ack_tgl),
                           .q_o(cap_ack_s));

   assign xing.en_val = byte_q[ptg_pkg::IDX_PRESCALE_EN[4:0]][ptg_pkg::BIT_ENABLE];
   assign xing.cnt_top = cmp_b_clr_q;

   // Deep sleep level registered so the core sees a clean flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xing.deep_sleep <= 1'b0;
      end else begin
         xing.deep_sleep <= sleep_mode_i >= ptg_pkg::SLEEP_STANDBY;
      end
   end

   // Any accepted enable write starts a transfer; pending blocks the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xing.en_req_tgl <= 1'b0;
         en_pend_q <= 1'b0;
      end else if (lo_wr && idx == ptg_pkg::IDX_PRESCALE_EN && !en_pend_q) begin
         xing.en_req_tgl <= !xing.en_req_tgl;
         en_pend_q <= 1'b1;
      end else if (en_pend_q && en_ack_s == xing.en_req_tgl) begin
         en_pend_q <= 1'b0;
      end
   end

   // Software capture strobes, ignored while a command is in flight
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xing.cap_req_tgl <= 1'b0;
         xing.cap_sel_b <= 1'b0;
         cap_pend_q <= 1'b0;
      end else if (lo_wr && idx == ptg_pkg::IDX_CMD_STROBES && !cap_pend_q &&
                   (wb8[ptg_pkg::BIT_SCAPT_A] || wb8[ptg_pkg::BIT_SCAPT_B])) begin
         xing.cap_req_tgl <= !xing.cap_req_tgl;
         xing.cap_sel_b <= !wb8[ptg_pkg::BIT_SCAPT_A];
         cap_pend_q <= 1'b1;
      end else if (cap_pend_q && cap_ack_s == xing.cap_req_tgl) begin
         cap_pend_q <= 1'b0;
      end
   end

   // Captured count is stable in the core once its done toggle is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capt_a_q <= ptg_pkg::RST_CMP;
         capt_b_q <= ptg_pkg::RST_CMP;
      end else if (cap_pend_q && cap_ack_s == xing.cap_req_tgl) begin
         if (xing.cap_sel_b) begin
            capt_b_q <= xing.cap_val;
         end else begin
            capt_a_q <= xing.cap_val;
         end
      end
   end

   ptg_timer_core u_core (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .x(xing.core_side),
      .count_o(count_o),
      .running_o(running_o)
   );
endmodule : ptg_reg_guard
`default_nettype wire

// ### rtl/ptg_sync_bit.sv
// Two-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module ptg_sync_bit (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Synchronous reset
   input wire logic d_i, // Level from other domain
   output logic q_o // Synchronised level
);
   logic meta_q;
   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : ptg_sync_bit
`default_nettype wire

// ### rtl/ptg_timer_core.sv
// Timer-domain counter with enable and capture handshakes.
`timescale 1ns/1ps
`default_nettype none
module ptg_timer_core (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Synchronous reset
   ptg_xing_if.core_side x, // Crossing from bus side
   output logic [11:0] count_o, // Counter value
   output logic running_o // Counter advancing
);
   logic en_req_s, cap_req_s, sleep_s, cnt_en_q;
   ptg_sync_bit u_en (.clk_i(clk_i), .rst_i(rst_i), .d_i(x.en_req_tgl), .q_o(en_req_s));
   ptg_sync_bit u_cap (.clk_i(clk_i), .rst_i(rst_i), .d_i(x.cap_req_tgl), .q_o(cap_req_s));
   ptg_sync_bit u_slp (.clk_i(clk_i), .rst_i(rst_i), .d_i(x.deep_sleep), .q_o(sleep_s));
   // Take the enable value once its request toggle arrives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_en_q <= 1'b0;
         x.en_ack_tgl <= 1'b0;
      end else if (en_req_s != x.en_ack_tgl) begin
         cnt_en_q <= x.en_val;
         x.en_ack_tgl <= en_req_s;
      end
   end
   // Count, frozen in deep sleep so nothing advances there
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= 12'h000;
         running_o <= 1'b0;
      end else begin
         running_o <= cnt_en_q && !sleep_s;
         if (cnt_en_q && !sleep_s) begin
            count_o <= (count_o >= x.cnt_top) ? 12'h000 : count_o + 12'h001;
         end
      end
   end
   // Capture holds its value until the next request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         x.cap_val <= 12'h000;
         x.cap_ack_tgl <= 1'b0;
      end else if (cap_req_s != x.cap_ack_tgl) begin
         x.cap_val <= count_o;
         x.cap_ack_tgl <= cap_req_s;
      end
   end
endmodule : ptg_timer_core
`default_nettype wire

// ### testbench/ptg_reg_guard_props.sv
// Assertion checker for the PWM timer register guard.
`timescale 1ns/1ps
`default_nettype none
module ptg_reg_guard_props (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Synchronous reset
   input wire logic por_i, // Power-on reset flag
   input wire logic [7:0] timer_config_fuse_i, // Fuse image
   input wire logic [1:0] sleep_mode_i, // Sleep level
   input wire logic [7:0] adr_i, // Byte address
   input wire logic [31:0] dat_i, // Write data
   input wire logic [3:0] sel_i, // Byte selects
   input wire logic we_i, // Write enable
   input wire logic cyc_i, // Cycle
   input wire logic stb_i, // Strobe
   input wire logic [31:0] dat_o, // Read data
   input wire logic ack_o, // Acknowledge
   input wire logic [7:0] fault_output_defaults_o, // Protected register
   input wire logic [11:0] count_o, // Timer count
   input wire logic running_o // Timer advancing
);
   // ************************************************************
   // Unlock window model
   // ************************************************************
   logic [2:0] win_q; // Completed accesses left in the window
   logic req;
   logic fault_wr;
   logic key_wr;
   assign req = cyc_i && stb_i;
   assign fault_wr = ack_o && req && we_i && sel_i[0] && adr_i[7:2] == ptg_pkg::IDX_FAULT_DEF;
   assign key_wr = ack_o && req && we_i && sel_i[0] && adr_i[7:2] == ptg_pkg::IDX_PROT_KEY
                   && dat_i[7:0] == ptg_pkg::IO_REG_UNLOCK_KEY;
   // Key opens; a protected write closes; any other completed access counts down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_q <= 3'h0;
      end else if (key_wr) begin
         win_q <= ptg_pkg::UNLOCK_WINDOW;
      end else if (fault_wr) begin
         win_q <= 3'h0;
      end else if (ack_o && req && win_q != 3'h0) begin
         win_q <= win_q - 3'h1;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ************************************************************
   // Properties
   // ************************************************************
   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   a_ack_follows_req: assert property (req && !ack_o |=> ack_o)
      else $error("request not answered in one cycle");
   a_ack_needs_req: assert property (!req |=> !ack_o)
      else $error("acknowledge without request");
   a_unmapped_reads_zero: assert property (req && !we_i && !ack_o &&
      (adr_i[7:2] == 6'h05 || adr_i[7:2] >= ptg_pkg::IDX_PROT_KEY) |=> ack_o && dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_locked_write_kept: assert property (fault_wr && win_q == 3'h0 |=> $stable(fault_output_defaults_o))
      else $error("locked fault register changed");
   a_open_write_taken: assert property (fault_wr && win_q != 3'h0 |=> fault_output_defaults_o == $past(dat_i[7:0]))
      else $error("unlocked fault write not taken");
   a_fault_change_cause: assert property ($changed(fault_output_defaults_o) |-> $past(fault_wr) || $past(rst_i) || $past(rst_i, 2))
      else $error("fault register changed without cause");
   a_deep_sleep_halts: assert property ((sleep_mode_i >= ptg_pkg::SLEEP_STANDBY)[*4] |=> !running_o && $stable(count_o))
      else $error("timer advancing in deep sleep");
   // Main scenarios reached
   c_open_write: cover property (fault_wr && win_q != 3'h0);
   c_locked_write: cover property (fault_wr && win_q == 3'h0);
   c_idle_running: cover property (running_o && sleep_mode_i == 2'h1);
endmodule : ptg_reg_guard_props
bind ptg_reg_guard ptg_reg_guard_props u_ptg_reg_guard_props (.clk_i(clk_i), .rst_i(rst_i),
   .por_i(por_i), .timer_config_fuse_i(timer_config_fuse_i), .sleep_mode_i(sleep_mode_i),
   .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .dat_o(dat_o), .ack_o(ack_o), .fault_output_defaults_o(fault_output_defaults_o),
   .count_o(count_o), .running_o(running_o));
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the PWM timer register guard.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] FLT = {ptg_pkg::IDX_FAULT_DEF, 2'b00};
   localparam logic [7:0] KEY = {ptg_pkg::IDX_PROT_KEY, 2'b00};
   localparam logic [7:0] ST = {ptg_pkg::IDX_STATUS, 2'b00};
   logic clk_i, rst_i, por_i, we_i, cyc_i, stb_i, ack_o, running_o;
   logic [7:0] timer_config_fuse_i, adr_i, fault_output_defaults_o, cur;
   logic [1:0] sleep_mode_i;
   logic [3:0] sel_i;
   logic [11:0] count_o;
   logic [31:0] dat_i, dat_o, rd, r;
   logic [31:0] seed = 32'h48519b62;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [5:0] plain_idx[13] = '{6'h01, 6'h02, 6'h03, 6'h08, 6'h09, 6'h0c, 6'h10, 6'h11,
                                 6'h14, 6'h15, 6'h18, 6'h19, 6'h1e};
   logic [5:0] cmp_idx[4] = '{6'h28, 6'h2a, 6'h2c, 6'h2e};
   int err_count = 0;
   int n_compared = 0;
   ptg_reg_guard u_ptg_reg_guard (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
      .timer_config_fuse_i(timer_config_fuse_i), .sleep_mode_i(sleep_mode_i), .adr_i(adr_i),
      .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
      .ack_o(ack_o), .fault_output_defaults_o(fault_output_defaults_o), .count_o(count_o),
      .running_o(running_o));
   // ************************************************************
   // Clock, random source, compare and verdict
   // ************************************************************
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task stop_test();
      if (err_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   // One classic cycle; a read notes its expected data and mask, mask zero means poll only
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      int n;
      @(posedge clk_i);
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= w ? d : 32'h0;
      sel_i <= 4'h3;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         $display("BAD %0t no acknowledge", $time);
         stop_test();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   // Poll until the chosen status ready bit reads one
   task wait_ready(input int b);
      int k;
      k = 0;
      do begin
         wb(1'b0, ST, 32'h0, 32'h0);
         k++;
      end while (rd[b] !== 1'b1 && k < 20);
      if (k >= 20) begin
         err_count++;
         $display("BAD %0t status never ready", $time);
         stop_test();
      end
   endtask : wait_ready
   // Reset for three edges with a fresh fuse image
   task do_reset(input logic p);
      r = rnd();
      rst_i <= 1'b1;
      por_i <= p;
      timer_config_fuse_i <= r[7:0];
      repeat (3) @(posedge clk_i);
      check({24'h0, fault_output_defaults_o}, {24'h0, p ? 8'h00 : cur});
      rst_i <= 1'b0;
      por_i <= 1'b0;
      cur = r[7:0];
   endtask : do_reset
   // Read results are matched against the oldest note
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
         if (msk_q[0] != 32'h0) check(dat_o & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {rst_i, por_i, we_i, cyc_i, stb_i} = 5'b11000;
      {timer_config_fuse_i, adr_i, sleep_mode_i, sel_i, dat_i, cur} = '0;
      do_reset(1'b1);
      wb(1'b0, FLT, {24'h0, cur}, 32'hff);
      // Locked write and a wrong key both leave the register alone
      r = rnd();
      wb(1'b1, FLT, r, 32'h0);
      wb(1'b0, FLT, {24'h0, cur}, 32'hff);
      wb(1'b1, KEY, {24'h0, ptg_pkg::IO_REG_UNLOCK_KEY ^ 8'h01}, 32'h0);
      wb(1'b1, FLT, ~r, 32'h0);
      wb(1'b0, FLT, {24'h0, cur}, 32'hff);
      // Window edges: 0 to 3 accesses between key and write succeed, 4 do not
      for (int n = 0; n < 5; n++) begin
         r = rnd();
         wb(1'b1, KEY, {24'h0, ptg_pkg::IO_REG_UNLOCK_KEY}, 32'h0);
         repeat (n) wb(1'b0, FLT, {24'h0, cur}, 32'hff);
         wb(1'b1, FLT, r, 32'h0);
         if (n < 4) cur = r[7:0];
         wb(1'b1, FLT, ~r, 32'h0);
         wb(1'b0, FLT, {24'h0, cur}, 32'hff);
         check({24'h0, fault_output_defaults_o}, {24'h0, cur});
      end
      // Other registers take writes freely; unmapped and key places read zero
      foreach (cmp_idx[i]) begin
         r = rnd();
         wb(1'b1, {cmp_idx[i], 2'b00}, r, 32'h0);
         wb(1'b0, {cmp_idx[i], 2'b00}, r, 32'hfff);
      end
      foreach (plain_idx[i]) begin
         r = rnd();
         wb(1'b1, {plain_idx[i], 2'b00}, r, 32'h0);
         wb(1'b0, {plain_idx[i], 2'b00}, r, 32'hff);
      end
      wb(1'b1, 8'h14, rnd(), 32'h0);
      wb(1'b0, 8'h14, 32'h0, 32'hffffffff);
      wb(1'b0, KEY, 32'h0, 32'hffffffff);
      // Enable crosses, runs in idle sleep, halts in both deep sleeps
      wb(1'b1, 8'h00, 32'h1, 32'h0);
      wait_ready(0);
      sleep_mode_i <= 2'h1;
      repeat (4) @(posedge clk_i);
      wb(1'b0, ST, 32'h41, 32'h41);
      check({31'h0, running_o}, 32'h1);
      for (int s = 2; s < 4; s++) begin
         sleep_mode_i <= s[1:0];
         repeat (4) @(posedge clk_i);
         wb(1'b0, ST, 32'h01, 32'h41);
         check({31'h0, running_o}, 32'h0);
      end
      sleep_mode_i <= 2'h0;
      // Second enable write lands while the first still crosses and is refused
      wb(1'b1, 8'h00, 32'h0, 32'h0);
      wb(1'b1, 8'h00, 32'h1, 32'h0);
      wait_ready(0);
      wb(1'b0, 8'h00, 32'h0, 32'h1);
      repeat (4) @(posedge clk_i);
      check({31'h0, running_o}, 32'h0);
      // Stopped counter is captured into A, then B; both must hold the frozen count
      for (int b = 3; b < 5; b++) begin
         wb(1'b1, 8'h10, 32'h1 << b, 32'h0);
         wait_ready(1);
         wb(1'b0, b == 3 ? 8'h88 : 8'h90, {20'h0, count_o}, 32'hfff);
      end
      // Warm reset keeps then reloads; power-on reset clears then reloads
      do_reset(1'b0);
      wb(1'b0, FLT, {24'h0, cur}, 32'hff);
      do_reset(1'b1);
      wb(1'b0, FLT, {24'h0, cur}, 32'hff);
      stop_test();
   end
endmodule : tb
`default_nettype wire
